// >>> mdms_slave.sv
// mdms_slave.sv: device-side slave of the two-wire management link.
// assumes: mdc and mdio come from another domain; mdc well below mclk/4.
`timescale 1ns/100ps
module mdms_slave
    import mdms_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // strap, caught while reset is held
    input  wire logic [4:0] phy_addr_strap,
    // management link pins
    input  wire logic       mdc,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_oe,
    // status
    output logic            no_preamble_accept,
    output logic [4:0]      phy_addr
);
    // ---------------------------------------------------------------
    // pin synchronisers and edge detection
    // ---------------------------------------------------------------
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
    logic dio_s1_q, dio_s2_q;
    logic rise_ev, fall_ev;

    // no mode input touches the pins: they work whatever the mac mode
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            dio_s1_q <= 1'b1;
            dio_s2_q <= 1'b1;
        end
        else
        begin
            mdc_s1_q <= mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            dio_s1_q <= mdio_i;
            dio_s2_q <= dio_s1_q;
        end
    end

    // both lines see the same delay, so data pairs with its own edge
    assign rise_ev = mdc_s2_q & ~mdc_s3_q;
    assign fall_ev = ~mdc_s2_q & mdc_s3_q;

    // ---------------------------------------------------------------
    // frame decoder state
    // ---------------------------------------------------------------
    mdms_state_t state_q;
    logic [5:0]  pre_cnt_q;
    logic [4:0]  cnt_q;
    mdms_hdr_t   hdr_q;
    mdms_hdr_t   hdr_nx;
    logic        hdr_ok;
    logic        is_rd_q;
    logic [15:0] sh_q;
    logic        bit_in;
    logic        override_q;
    logic        npa_q;
    logic [4:0]  phy_q;
    logic [15:0] rd_mem;
    logic [15:0] rd_word;
    logic        impl;
    logic        wr_fire;
    logic [15:0] wr_word;
    mdms_wr_t    wr;

    assign bit_in = dio_s2_q;
    assign hdr_nx = mdms_hdr_t'({hdr_q[10:0], bit_in});
    assign hdr_ok = (hdr_nx.op == `MDMS_OP_RD || hdr_nx.op == `MDMS_OP_WR)
                    && hdr_nx.phy == phy_q;
    // mask shifted down to the addressed bit, kept to that one bit on purpose
    assign impl   = 1'(`MDMS_IMPL_MASK >> hdr_q.reg_addr);

    // preamble: count consecutive ones, saturating; any zero restarts
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            pre_cnt_q <= 6'd0;
        else if (rise_ev)
        begin
            if (!bit_in || state_q != ST_HUNT)
                pre_cnt_q <= 6'd0;
            else if (pre_cnt_q != `MDMS_PRE_LEN)
                pre_cnt_q <= pre_cnt_q + 6'd1;
        end
    end

    // frame sequence, one step per rising mdc
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_HUNT;
            cnt_q   <= 5'd0;
            hdr_q   <= '0;
            is_rd_q <= 1'b0;
        end
        else if (rise_ev)
        begin
            case (state_q)
                ST_HUNT:
                    if (!bit_in && (npa_q || pre_cnt_q == `MDMS_PRE_LEN))
                        state_q <= ST_SFD;
                ST_SFD:
                begin
                    cnt_q   <= 5'd0;
                    state_q <= bit_in ? ST_HDR : ST_HUNT;
                end
                ST_HDR:
                begin
                    hdr_q <= hdr_nx;
                    cnt_q <= cnt_q + 5'd1;
                    if (cnt_q == `MDMS_HDR_LAST)
                    begin
                        cnt_q   <= 5'd0;
                        is_rd_q <= hdr_nx.op == `MDMS_OP_RD;
                        state_q <= hdr_ok ? ST_TA : ST_SKIP;
                    end
                end
                ST_TA:
                begin
                    // on a write the manager owns these two bits
                    cnt_q <= cnt_q + 5'd1;
                    if (cnt_q == `MDMS_TA_LAST)
                    begin
                        cnt_q   <= 5'd0;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    cnt_q <= cnt_q + 5'd1;
                    if (cnt_q == `MDMS_DATA_LAST)
                        state_q <= ST_HUNT;
                end
                ST_SKIP:
                begin
                    // sit out the rest so payload zeros never look like a start
                    cnt_q <= cnt_q + 5'd1;
                    if (cnt_q == `MDMS_SKIP_LAST)
                        state_q <= ST_HUNT;
                end
                default:
                    state_q <= ST_HUNT;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // data shift register: loaded for reads, filled for writes
    // ---------------------------------------------------------------
    always_comb
    begin
        rd_word = impl ? rd_mem : `MDMS_ALL_ONES;
        if (impl && hdr_q.reg_addr == `MDMS_REG_STATUS)
            rd_word[`MDMS_NPA_BIT] = npa_q;
        if (impl && hdr_q.reg_addr == `MDMS_REG_EXTCTL)
        begin
            rd_word[`MDMS_OVR_BIT] = override_q;
            rd_word[`MDMS_PHY_MSB:`MDMS_PHY_LSB] = phy_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            sh_q <= 16'h0000;
        else if (rise_ev && state_q == ST_TA && cnt_q == `MDMS_TA_LAST)
            sh_q <= rd_word;
        else if (rise_ev && state_q == ST_DATA && !is_rd_q)
            sh_q <= {sh_q[14:0], bit_in};
        else if (fall_ev && state_q == ST_DATA && is_rd_q)
            sh_q <= {sh_q[14:0], 1'b0};
    end

    // ---------------------------------------------------------------
    // pin drive: changes only on falling mdc, stable at next rise
    // ---------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            mdio_o  <= 1'b0;
            mdio_oe <= 1'b0;
        end
        else if (fall_ev)
        begin
            if (state_q == ST_TA && is_rd_q && cnt_q == `MDMS_TA_LAST)
            begin
                mdio_oe <= 1'b1;
                mdio_o  <= 1'b0;
            end
            else if (state_q == ST_DATA && is_rd_q)
            begin
                mdio_oe <= 1'b1;
                mdio_o  <= sh_q[15];
            end
            else
            begin
                mdio_oe <= 1'b0;
                mdio_o  <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // write commit and control bits
    // ---------------------------------------------------------------
    assign wr_fire = rise_ev && state_q == ST_DATA && !is_rd_q
                     && cnt_q == `MDMS_DATA_LAST && impl;
    assign wr_word = {sh_q[14:0], bit_in};
    assign wr      = '{en: wr_fire, addr: hdr_q.reg_addr, data: wr_word};

    // override arms the next write, and any accepted write consumes it
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            override_q <= 1'b0;
        else if (wr_fire)
            override_q <= hdr_q.reg_addr == `MDMS_REG_EXTCTL
                          && wr_word[`MDMS_OVR_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            npa_q <= 1'b0;
        else if (wr_fire && override_q && hdr_q.reg_addr == `MDMS_REG_STATUS)
            npa_q <= wr_word[`MDMS_NPA_BIT];
    end

    // strap sampled by the clock while reset is low
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phy_q <= phy_addr_strap;
        else if (wr_fire && hdr_q.reg_addr == `MDMS_REG_EXTCTL)
            phy_q <= wr_word[`MDMS_PHY_MSB:`MDMS_PHY_LSB];
    end

    assign no_preamble_accept = npa_q;
    assign phy_addr           = phy_q;

    mdms_regfile u_regs (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .wr        (wr),
        .rd_addr   (hdr_q.reg_addr),
        .rd_data_q (rd_mem)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_PRE_NEEDED: assert property (
        state_q == ST_HUNT && rise_ev && !npa_q && pre_cnt_q != `MDMS_PRE_LEN
        && !bit_in |=> state_q == ST_HUNT)
        else $error("start taken without full preamble");
    AST_SUPP_START: assert property (
        state_q == ST_HUNT && rise_ev && npa_q && !bit_in |=> state_q == ST_SFD)
        else $error("suppressed start not taken");
    AST_NPA_GATED: assert property (
        $rose(npa_q) |-> $past(override_q) && $past(wr_fire))
        else $error("suppression set without override");
    AST_BAD_SFD: assert property (
        state_q == ST_SFD && rise_ev && !bit_in |=> state_q == ST_HUNT)
        else $error("bad delimiter accepted");
    AST_IGNORE: assert property (
        state_q == ST_HDR && rise_ev && cnt_q == `MDMS_HDR_LAST && !hdr_ok
        |=> state_q == ST_SKIP ##1 !mdio_oe [*8])
        else $error("ignored frame not skipped");
    AST_TA_Z: assert property (
        state_q == ST_TA && fall_ev && cnt_q == 5'd0 |=> !mdio_oe)
        else $error("first turnaround bit driven");
    AST_TA_LOW: assert property (
        state_q == ST_TA && fall_ev && is_rd_q && cnt_q == `MDMS_TA_LAST
        |=> mdio_oe && !mdio_o)
        else $error("second turnaround bit not low");
    AST_UNIMPL_RD: assert property (
        state_q == ST_DATA && fall_ev && is_rd_q && !impl |=> mdio_o)
        else $error("unimplemented read not all ones");
    AST_RELEASE: assert property (
        state_q == ST_HUNT && fall_ev |=> !mdio_oe)
        else $error("pin driven while idle");
    AST_OVR_CLEAR: assert property (
        wr_fire && hdr_q.reg_addr != `MDMS_REG_EXTCTL |=> !override_q)
        else $error("override not self cleared");

    COV_READ: cover property (state_q == ST_DATA && is_rd_q && rise_ev
                              && cnt_q == `MDMS_DATA_LAST);
    COV_WRITE: cover property (wr_fire);
    COV_NPA: cover property ($rose(npa_q));
    COV_SKIP: cover property (state_q == ST_SKIP);
endmodule : mdms_slave

// >>> mdms_defs.svh
// mdms_defs.svh: offsets, field positions, reset values and counts of the
// management serial slave.
// assumes: included by bare name from the package, the manager model and the bench.
`ifndef MDMS_DEFS_SVH
`define MDMS_DEFS_SVH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define MDMS_PRE_LEN      6'd32
`define MDMS_OP_RD        2'b10
`define MDMS_OP_WR        2'b01
`define MDMS_HDR_LAST     5'd11
`define MDMS_TA_LAST      5'd1
`define MDMS_DATA_LAST    5'd15
`define MDMS_SKIP_LAST    5'd17

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define MDMS_REG_STATUS   5'd1
`define MDMS_REG_EXTCTL   5'd16
`define MDMS_NPA_BIT      6
`define MDMS_OVR_BIT      15
`define MDMS_PHY_LSB      6
`define MDMS_PHY_MSB      10
`define MDMS_IMPL_MASK    32'h000f_01ff
`define MDMS_ALL_ONES     16'hffff
`define MDMS_REG_RST      16'h0000

`endif

// >>> mdms_pkg.sv
// mdms_pkg.sv: types shared by the management serial slave files.
// assumes: mdms_defs.svh is on the include path.
package mdms_pkg;
    `include "mdms_defs.svh"

    // frame decoder states
    typedef enum logic [2:0] {
        ST_HUNT = 3'b000,
        ST_SFD  = 3'b001,
        ST_HDR  = 3'b010,
        ST_TA   = 3'b011,
        ST_DATA = 3'b100,
        ST_SKIP = 3'b101
    } mdms_state_t;

    // header fields in arrival order
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] reg_addr;
    } mdms_hdr_t;

    // register file write request
    typedef struct packed {
        logic        en;
        logic [4:0]  addr;
        logic [15:0] data;
    } mdms_wr_t;
endpackage : mdms_pkg

// >>> mdms_regfile.sv
// mdms_regfile.sv: 32 x 16 management register storage, registered read.
// assumes: single clock mclk, synchronous active-low reset.
`timescale 1ns/100ps
module mdms_regfile
    import mdms_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // write port
    input  wire mdms_wr_t    wr,
    // read port
    input  wire logic [4:0]  rd_addr,
    output logic      [15:0] rd_data_q
);
    logic [15:0] mem_q [32];

    // ---------------------------------------------------------------
    // storage, one entry per generate step
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++)
        begin : g_ent
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    mem_q[gi] <= `MDMS_REG_RST;
                else if (wr.en && wr.addr == 5'(gi))
                    mem_q[gi] <= wr.data;
            end
        end
    endgenerate

    // read data registered: one cycle latency, plenty inside a bit time
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rd_data_q <= `MDMS_REG_RST;
        else
            rd_data_q <= mem_q[rd_addr];
    end
endmodule : mdms_regfile

// >>> mdms_sta_model.sv
// mdms_sta_model.sv: behavioural station manager driving the management link.
// assumes: the bench resolves the data wire with a pull-up and feeds wire_i.
`timescale 1ns/100ps
`include "mdms_defs.svh"
module mdms_sta_model
    import mdms_pkg::*;
(
    // bit timing reference
    input  wire logic mclk,
    // link, manager side
    output logic      mdc,
    output logic      sta_o,
    output logic      sta_oe,
    input  wire logic wire_i
);
    // mdc stands low between frames, line released
    initial
    begin
        mdc    = 1'b0;
        sta_o  = 1'b1;
        sta_oe = 1'b0;
    end

    // wait n mclk edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // one bit time of 8 mclk: change while mdc low, sample at the rise
    task automatic bit_t(input logic drv, input logic val, output logic smp);
        sta_oe = drv;
        sta_o  = val;
        tick(4);
        mdc    = 1'b1;
        smp    = wire_i;
        tick(4);
        mdc    = 1'b0;
    endtask : bit_t

    // whole frame; rd holds the 18 wire bits seen from turnaround on
    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [17:0] rd);
        logic [13:0] hdr;
        logic        rdop;
        logic        s;
        hdr  = {2'b01, op, phy, ra};
        rdop = (op == `MDMS_OP_RD);
        repeat (pre) bit_t(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_t(1'b1, hdr[i], s);
        for (int i = 17; i >= 0; i--)
        begin
            // manager is passive on reads, sends 1 0 then data on writes
            bit_t(!rdop, (i == 17) ? 1'b1 : (i == 16) ? 1'b0 : wd[i & 15], s);
            rd[i] = s;
        end
        sta_oe = 1'b0;
    endtask : frame
endmodule : mdms_sta_model

// >>> mdio_management_slave_test.sv
// mdio_management_slave_test.sv: self-checking bench of the management slave.
// assumes: mdms_sta_model plays the manager; data wire has a pull-up.
`timescale 1ns/100ps
`include "mdms_defs.svh"
module mdio_management_slave_test
    import mdms_pkg::*;
;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam logic [4:0]  STRAP = 5'h05;
    localparam logic [1:0]  RD    = `MDMS_OP_RD;
    localparam logic [1:0]  WR    = `MDMS_OP_WR;
    localparam logic [15:0] ADR16 = {5'h00, STRAP, 6'h00};
    logic        mclk;
    logic        rst_n;
    logic [4:0]  phy_addr_strap;
    logic        mdc;
    logic        mdio_i;
    logic        mdio_o;
    logic        mdio_oe;
    logic        sta_o;
    logic        sta_oe;
    logic        no_preamble_accept;
    logic [4:0]  phy_addr;
    logic [17:0] got;
    logic        oe_prev = 1'b0;
    int          oe_cnt = 0;
    int          c0;
    int          n_mismatch = 0;
    int          total_checks = 0;

    // ---------------------------------------------------------------
    // ordinary cases: frame fields beside expected pin drive and data
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [5:0] pre; logic [1:0] op; logic [4:0] phy; logic [4:0] ra;
        logic [15:0] wd; logic chk; logic oe; logic [17:0] want;
    } mdms_row_t;
    localparam int NROW = 17;
    mdms_row_t rows [NROW] = '{
        '{6'd32, WR, STRAP, 5'd0, 16'ha5c3, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd0, 16'h0, 1'b1, 1'b1, 18'h2a5c3},
        '{6'd32, WR, STRAP, 5'd19, 16'h8001, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd19, 16'h0, 1'b1, 1'b1, 18'h28001},
        '{6'd32, RD, STRAP, 5'd9, 16'h0, 1'b1, 1'b1, 18'h2ffff},
        '{6'd32, WR, STRAP, 5'd20, 16'h1234, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd20, 16'h0, 1'b1, 1'b1, 18'h2ffff},
        '{6'd32, RD, STRAP, 5'd0, 16'h0, 1'b1, 1'b1, 18'h2a5c3},
        '{6'd32, WR, 5'h06, 5'd0, 16'h0, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, 5'h06, 5'd0, 16'h0, 1'b1, 1'b0, 18'h3ffff},
        '{6'd32, 2'b00, STRAP, 5'd0, 16'h0, 1'b0, 1'b0, 18'h0},
        '{6'd32, 2'b11, STRAP, 5'd0, 16'h0, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd0, 16'h0, 1'b1, 1'b1, 18'h2a5c3},
        '{6'd32, WR, STRAP, 5'd8, 16'h00ff, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd8, 16'h0, 1'b1, 1'b1, 18'h200ff},
        '{6'd32, WR, STRAP, 5'd1, 16'h0040, 1'b0, 1'b0, 18'h0},
        '{6'd32, RD, STRAP, 5'd1, 16'h0, 1'b1, 1'b1, 18'h20000}
    };

    // ---------------------------------------------------------------
    // design, manager and wire
    // ---------------------------------------------------------------
    mdms_slave mdms_slave_i (
        .mclk(mclk), .rst_n(rst_n), .phy_addr_strap(phy_addr_strap),
        .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
        .no_preamble_accept(no_preamble_accept), .phy_addr(phy_addr)
    );
    mdms_sta_model mdms_sta_model_i (
        .mclk(mclk), .mdc(mdc), .sta_o(sta_o), .sta_oe(sta_oe), .wire_i(mdio_i)
    );
    // pull-up wins when neither side drives
    assign mdio_i = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);

    // clock, 50 ns period
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // count rises of the device drive, one per answered read
    always @(posedge mclk)
    begin
        oe_prev <= mdio_oe;
        if (mdio_oe === 1'b1 && oe_prev !== 1'b1) oe_cnt <= oe_cnt + 1;
    end

    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] %0t ns: %s", $time, what);
        end
    endtask : check

    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // hang guard, well beyond the few dozen frames sent
    initial
    begin
        repeat (60000) @(posedge mclk);
        n_mismatch++;
        $display("[ERR] %0t ns: run limit reached", $time);
        results();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        rst_n          = 1'b0;
        phy_addr_strap = STRAP;
        mdms_sta_model_i.tick(16);
        check(mdio_oe === 1'b0 && no_preamble_accept === 1'b0, "reset outputs");
        check(phy_addr === STRAP, "strap not taken");
        rst_n = 1'b1;
        mdms_sta_model_i.tick(4);
        // rows go back to back, no idle bit between frames
        for (int i = 0; i < NROW; i++)
        begin
            c0 = oe_cnt;
            mdms_sta_model_i.frame(rows[i].pre, rows[i].op, rows[i].phy, rows[i].ra,
                                   rows[i].wd, got);
            check((oe_cnt != c0) === rows[i].oe, "pin drive");
            if (rows[i].chk) check(got === rows[i].want, "read data");
        end
        // 31 ones only: frame must be ignored, hunt resumes
        mdms_sta_model_i.frame(31, WR, STRAP, 5'd0, 16'h0f0f, got);
        mdms_sta_model_i.frame(32, RD, STRAP, 5'd0, 16'h0, got);
        check(got === 18'h2a5c3, "short preamble accepted");
        mdms_sta_model_i.tick(6);
        check(mdio_oe === 1'b0, "pin held after read");
        // arm override, then set suppression
        mdms_sta_model_i.frame(32, WR, STRAP, 5'd16, 16'h8000 | ADR16, got);
        // a discarded write must not use up the armed override
        mdms_sta_model_i.frame(32, WR, STRAP, 5'd20, 16'h0000, got);
        mdms_sta_model_i.frame(32, WR, STRAP, 5'd1, 16'h0040, got);
        check(no_preamble_accept === 1'b1, "suppression not set");
        mdms_sta_model_i.frame(0, RD, STRAP, 5'd16, 16'h0, got);
        check(got === {2'b10, ADR16}, "override not cleared");
        // move the stored address, old one must go quiet
        mdms_sta_model_i.frame(0, WR, STRAP, 5'd16, {5'h00, 5'h07, 6'h00}, got);
        check(phy_addr === 5'h07, "address not stored");
        mdms_sta_model_i.frame(0, RD, 5'h07, 5'd0, 16'h0, got);
        check(got === 18'h2a5c3, "new address read");
        mdms_sta_model_i.frame(0, RD, STRAP, 5'd0, 16'h0, got);
        check(got === 18'h3ffff, "old address answered");
        // second reset clears suppression and registers
        rst_n = 1'b0;
        mdms_sta_model_i.tick(16);
        rst_n = 1'b1;
        check(no_preamble_accept === 1'b0 && phy_addr === STRAP, "second reset");
        mdms_sta_model_i.tick(4);
        mdms_sta_model_i.frame(0, RD, STRAP, 5'd0, 16'h0, got);
        check(got === 18'h3ffff, "answered without preamble");
        mdms_sta_model_i.frame(32, RD, STRAP, 5'd0, 16'h0, got);
        check(got === 18'h20000, "register not reset");
        results();
    end
endmodule : mdio_management_slave_test
